// ### rtl/sft_pkg.sv
package sft_pkg;

    // Widths.
    localparam int BYTE_W = 8;
    localparam int OFS_W  = 8;
    localparam int IRQ_W  = 3;
    localparam int ETU_CW = 6;

    // Register byte offsets on the bus.
    localparam logic [OFS_W-1:0] OFS_STOP     = 8'h00;
    localparam logic [OFS_W-1:0] OFS_CTRL     = 8'h04;
    localparam logic [OFS_W-1:0] OFS_STAT     = 8'h08;
    localparam logic [OFS_W-1:0] OFS_TDR      = 8'h0C;
    localparam logic [OFS_W-1:0] OFS_RDR      = 8'h10;
    localparam logic [OFS_W-1:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [OFS_W-1:0] OFS_IRQ_MASK = 8'h18;

    // Field positions.
    localparam int STOP_BIT    = 0;
    localparam int CTL_VARIANT = 0;
    localparam int CTL_TX_EN   = 1;
    localparam int CTL_TX_IE   = 2;
    localparam int CTL_RX_IE   = 3;
    localparam int ST_TX_EMPTY = 7;
    localparam int ST_RX_FULL  = 6;
    localparam int ST_OVERRUN  = 5;
    localparam int ST_RX_ERR   = 4;
    localparam int ST_ERR_SIG  = 3;
    localparam int ST_TX_END   = 2;
    localparam int IRQ_TX_END  = 0;
    localparam int IRQ_RX_FULL = 1;
    localparam int IRQ_RX_ERR  = 2;

    // Reset values.
    localparam logic              STOP_RST = 1'b1;
    localparam logic [BYTE_W-1:0] CTRL_RST = 8'h00;

    // Bus encodings.
    localparam logic [2:0] SIZE_WORD  = 3'h2;
    localparam int         TRANS_BUSY = 1;

    // Transmit-end delay after the start bit, in elementary time units.
    localparam real TX_END_ETU_V0 = 12.5;
    localparam real TX_END_ETU_V1 = 11.0;
    localparam logic [ETU_CW-1:0] HALF_ETU_V0 =
        ETU_CW'($rtoi(TX_END_ETU_V0 * 2.0));
    localparam logic [ETU_CW-1:0] HALF_ETU_V1 =
        ETU_CW'($rtoi(TX_END_ETU_V1 * 2.0));

    typedef enum logic [0:0] {
        SFT_TX_IDLE = 1'b0,
        SFT_TX_SEND = 1'b1
    } sft_tx_e;

endpackage

// ### rtl/sft_etu_timer.sv
`timescale 1ns/1ps
module sft_etu_timer #(
    parameter int CW = 6
) (
    // Clock and reset.
    input  wire logic          clk,
    input  wire logic          rst,
    // Control.
    input  wire logic          start,
    input  wire logic          tick,
    input  wire logic [CW-1:0] limit,
    // Status.
    output logic               done,
    output logic               busy
);
    import sft_pkg::*;

    typedef struct packed {
        logic          busy;
        logic          done;
        logic [CW-1:0] cnt;
    } sft_etu_s;

    sft_etu_s s_q;
    sft_etu_s s_d;

    // Half-unit ticks are counted from the start bit of the character.
    // Etu counting.
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (start) begin
            s_d.busy = 1'b1;
            s_d.cnt = '0;
        end else if (s_q.busy && tick) begin
            s_d.cnt = CW'(s_q.cnt + 1'b1);
            if (s_d.cnt == limit) begin
                s_d.done = 1'b1;
                s_d.busy = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done = s_q.done;
    assign busy = s_q.busy;

    a_etu_limit: assert property (
        @(posedge clk) disable iff (rst)
        s_q.busy && !start && tick && (s_q.cnt == CW'(limit - 1'b1))
        |=> done && !busy
    ) else $error("Etu timer missed its limit.");

endmodule

// ### rtl/sft_ahb_port.sv
`timescale 1ns/1ps
module sft_ahb_port (
    // Clock and reset.
    input  wire logic                      clk,
    input  wire logic                      rst,
    // Bus address phase.
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic                      hready,
    // Decoded accesses.
    output logic                           wr_en,
    output logic [sft_pkg::OFS_W-1:0]      wr_ofs,
    output logic                           rd_en,
    output logic [sft_pkg::OFS_W-1:0]      rd_ofs
);
    import sft_pkg::*;

    typedef struct packed {
        logic             wr_pend;
        logic [OFS_W-1:0] ofs;
    } sft_ahb_s;

    sft_ahb_s s_q;
    sft_ahb_s s_d;
    logic     take;

    // Only whole-word transfers are taken; others complete with no effect.
    assign take = hsel && htrans[TRANS_BUSY] && hready
                  && (hsize == SIZE_WORD);

    always_comb begin
        s_d = s_q;
        s_d.wr_pend = take && hwrite;
        if (take && hwrite) begin
            s_d.ofs = haddr[OFS_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign wr_en  = s_q.wr_pend;
    assign wr_ofs = s_q.ofs;
    assign rd_en  = take && !hwrite;
    assign rd_ofs = haddr[OFS_W-1:0];

endmodule

// ### rtl/sft_flag_ctrl.sv
// Contract
// - Controller write to transmit data clears the transmit-empty flag.
// - Controller read of receive data clears the receive-full flag.
// - Receive-error interrupt never starts a controller transfer.
// - Auto clearing only with disable-select zero and count nonzero.
// - After reset the interface is halted by module stop.
// - Registers are reachable only once module stop is cleared; the stop register itself stays reachable while stopped.
// - Writing zero to status bit 2 clears the transmit-end flag.
// - Controller write of transmit data clears the transmit-end flag.
// - Variant zero sets transmit-end 12.5 units after the character.
// - Variant one sets transmit-end 11.0 units after the character.
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module sft_flag_ctrl (
    // Clock and reset.
    input  wire logic                       SYS_CLK,
    input  wire logic                       RST,
    // Register bus.
    input  wire logic                       HSEL,
    input  wire logic [31:0]                HADDR,
    input  wire logic [1:0]                 HTRANS,
    input  wire logic                       HWRITE,
    input  wire logic [2:0]                 HSIZE,
    input  wire logic [31:0]                HWDATA,
    input  wire logic                       HREADY,
    output logic      [31:0]                HRDATA,
    output logic                            HREADYOUT,
    output logic                            HRESP,
    // Transfer controller.
    input  wire logic                       XFER_TX_WR,
    input  wire logic [sft_pkg::BYTE_W-1:0] XFER_TX_DATA,
    input  wire logic                       XFER_RX_RD,
    input  wire logic                       XFER_RX_SRC,
    input  wire logic                       XFER_DISABLE_SEL,
    input  wire logic                       XFER_COUNT_NZ,
    output logic      [sft_pkg::BYTE_W-1:0] XFER_RX_DATA,
    output logic                            XFER_REQ_TX,
    output logic                            XFER_REQ_RX,
    // Serial engine.
    input  wire logic                       BRG_HALF_TICK,
    input  wire logic                       RX_DONE,
    input  wire logic [sft_pkg::BYTE_W-1:0] RX_BYTE,
    input  wire logic                       RX_ERROR,
    input  wire logic                       ERR_SIGNAL,
    output logic                            TX_START,
    output logic      [sft_pkg::BYTE_W-1:0] TX_BYTE,
    // Interrupt.
    output logic                            IRQ
);
    import sft_pkg::*;

    typedef struct packed {
        logic              stop;
        logic [BYTE_W-1:0] ctrl;
        logic              tx_empty;
        logic              rx_full;
        logic              overrun;
        logic              rx_error;
        logic              err_sig;
        logic              tx_end;
        logic [BYTE_W-1:0] tx_data_register;
        logic [BYTE_W-1:0] rx_data_register;
        logic [IRQ_W-1:0]  irq_stat;
        logic [IRQ_W-1:0]  irq_mask;
        sft_tx_e           tx_st;
        logic              tx_start;
        logic [BYTE_W-1:0] tx_byte;
        logic [31:0]       rdata;
    } sft_main_s;

    localparam sft_main_s MAIN_RST = '{
        stop:     STOP_RST,
        ctrl:     CTRL_RST,
        tx_empty: 1'b1,
        tx_end:   1'b1,
        tx_st:    SFT_TX_IDLE,
        default:  '0
    };

    sft_main_s         s_q;
    sft_main_s         s_d;
    logic              wr_en;
    logic [OFS_W-1:0]  wr_ofs;
    logic              rd_en;
    logic [OFS_W-1:0]  rd_ofs;
    logic              on;
    logic              tx_auto;
    logic              rx_auto;
    logic              tx_go;
    logic              etu_done;
    logic [ETU_CW-1:0] etu_limit;

    // A stopped module answers only on its stop register.
    function automatic logic acc_ok(input logic [OFS_W-1:0] ofs,
                                    input logic stop);
        return (ofs == OFS_STOP) || !stop;
    endfunction

    function automatic logic [31:0] rd_word(input sft_main_s s,
                                            input logic [OFS_W-1:0] ofs);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (ofs)
            OFS_STOP: w[STOP_BIT] = s.stop;
            OFS_CTRL: w[BYTE_W-1:0] = s.ctrl;
            OFS_STAT: begin
                w[ST_TX_EMPTY] = s.tx_empty;
                w[ST_RX_FULL] = s.rx_full;
                w[ST_OVERRUN] = s.overrun;
                w[ST_RX_ERR] = s.rx_error;
                w[ST_ERR_SIG] = s.err_sig;
                w[ST_TX_END] = s.tx_end;
            end
            OFS_TDR: w[BYTE_W-1:0] = s.tx_data_register;
            OFS_RDR: w[BYTE_W-1:0] = s.rx_data_register;
            OFS_IRQ_STAT: w[IRQ_W-1:0] = s.irq_stat;
            OFS_IRQ_MASK: w[IRQ_W-1:0] = s.irq_mask;
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    sft_ahb_port u_ahb (
        .clk    (SYS_CLK),
        .rst    (RST),
        .hsel   (HSEL),
        .haddr  (HADDR),
        .htrans (HTRANS),
        .hwrite (HWRITE),
        .hsize  (HSIZE),
        .hready (HREADY),
        .wr_en  (wr_en),
        .wr_ofs (wr_ofs),
        .rd_en  (rd_en),
        .rd_ofs (rd_ofs)
    );

    assign etu_limit = s_q.ctrl[CTL_VARIANT] ? HALF_ETU_V1 : HALF_ETU_V0;

    // The timer starts with the start-bit pulse, so the delay counts
    // from the leading edge of the character.
    sft_etu_timer #(
        .CW (ETU_CW)
    ) u_etu (
        .clk   (SYS_CLK),
        .rst   (RST),
        .start (s_q.tx_start),
        .tick  (BRG_HALF_TICK),
        .limit (etu_limit),
        .done  (etu_done),
        .busy  ()
    );

    assign on = !s_q.stop;

    // Clear only with transfers enabled and count left.
    assign tx_auto = on && XFER_TX_WR && !XFER_DISABLE_SEL && XFER_COUNT_NZ;
    // Receive clear needs a receive-full activation.
    assign rx_auto = on && XFER_RX_RD && XFER_RX_SRC
                     && !XFER_DISABLE_SEL && XFER_COUNT_NZ;

    always_comb begin
        s_d = s_q;
        s_d.tx_start = 1'b0;
        tx_go = 1'b0;

        if (wr_en && acc_ok(wr_ofs, s_q.stop)) begin
            case (wr_ofs)
                OFS_STOP: s_d.stop = HWDATA[STOP_BIT];
                OFS_CTRL: s_d.ctrl = HWDATA[BYTE_W-1:0];
                OFS_STAT: begin
                    if (!HWDATA[ST_TX_EMPTY]) s_d.tx_empty = 1'b0;
                    if (!HWDATA[ST_RX_FULL]) s_d.rx_full = 1'b0;
                    if (!HWDATA[ST_OVERRUN]) s_d.overrun = 1'b0;
                    if (!HWDATA[ST_RX_ERR]) s_d.rx_error = 1'b0;
                    if (!HWDATA[ST_ERR_SIG]) s_d.err_sig = 1'b0;
                    if (!HWDATA[ST_TX_END]) s_d.tx_end = 1'b0;
                end
                OFS_TDR: s_d.tx_data_register = HWDATA[BYTE_W-1:0];
                OFS_IRQ_STAT: begin
                    s_d.irq_stat = s_q.irq_stat & ~HWDATA[IRQ_W-1:0];
                end
                OFS_IRQ_MASK: s_d.irq_mask = HWDATA[IRQ_W-1:0];
                default: s_d.ctrl = s_d.ctrl;
            endcase
        end

        if (on && XFER_TX_WR) begin
            s_d.tx_data_register = XFER_TX_DATA;
            s_d.tx_end = 1'b0;
        end
        if (tx_auto) begin
            s_d.tx_empty = 1'b0;
        end
        if (rx_auto) begin
            s_d.rx_full = 1'b0;
        end

        // Flag sets come after every clear, so a set in the same cycle wins.
        if (on && RX_DONE) begin
            if (s_d.rx_full) begin
                s_d.overrun = 1'b1;
            end else begin
                s_d.rx_data_register = RX_BYTE;
                s_d.rx_full = 1'b1;
                s_d.irq_stat[IRQ_RX_FULL] = 1'b1;
            end
        end
        if (on && RX_ERROR) begin
            s_d.rx_error = 1'b1;
            s_d.irq_stat[IRQ_RX_ERR] = 1'b1;
        end
        if (on && ERR_SIGNAL) begin
            s_d.err_sig = 1'b1;
        end

        case (s_q.tx_st)
            SFT_TX_IDLE: begin
                tx_go = on && s_q.ctrl[CTL_TX_EN] && !s_q.tx_empty;
            end
            SFT_TX_SEND: begin
                if (etu_done) begin
                    tx_go = on && s_q.ctrl[CTL_TX_EN] && !s_q.tx_empty;
                    s_d.tx_st = SFT_TX_IDLE;
                    if (s_q.tx_empty && !s_q.err_sig) begin
                        s_d.tx_end = 1'b1;
                        s_d.irq_stat[IRQ_TX_END] = 1'b1;
                    end
                end else if (s_q.stop) begin
                    s_d.tx_st = SFT_TX_IDLE;
                end
            end
            default: s_d.tx_st = SFT_TX_IDLE;
        endcase

        // Handing the byte to the shifter empties the data register.
        if (tx_go) begin
            s_d.tx_byte = s_q.tx_data_register;
            s_d.tx_empty = 1'b1;
            s_d.tx_start = 1'b1;
            s_d.tx_end = 1'b0;
            s_d.tx_st = SFT_TX_SEND;
        end

        // Read data is latched in the address phase, valid in data phase.
        if (rd_en) begin
            s_d.rdata = acc_ok(rd_ofs, s_q.stop) ? rd_word(s_q, rd_ofs)
                                                 : 32'h0000_0000;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            s_q <= MAIN_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign HRDATA       = s_q.rdata;
    assign HREADYOUT    = 1'b1;
    assign HRESP        = 1'b0;
    assign XFER_RX_DATA = s_q.rx_data_register;
    assign TX_START     = s_q.tx_start;
    assign TX_BYTE      = s_q.tx_byte;
    assign IRQ          = |(s_q.irq_stat & s_q.irq_mask);

    // Only empty and full requests activate.
    assign XFER_REQ_TX = on && s_q.tx_empty && s_q.ctrl[CTL_TX_IE];
    assign XFER_REQ_RX = on && s_q.rx_full && s_q.ctrl[CTL_RX_IE];

    a_auto_tx_clr: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        tx_auto && s_q.tx_empty |=> !s_q.tx_empty
    ) else $error("Transmit-empty not cleared by controller write.");

    a_auto_rx_clr: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        rx_auto && !RX_DONE |=> !s_q.rx_full
    ) else $error("Receive-full not cleared by controller read.");

    a_err_no_act: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        s_q.rx_error && !(s_q.tx_empty && s_q.ctrl[CTL_TX_IE])
        && !(s_q.rx_full && s_q.ctrl[CTL_RX_IE])
        |-> !XFER_REQ_TX && !XFER_REQ_RX
    ) else $error("Receive error started a transfer.");

    a_transfer_disable_select_keep: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        on && XFER_TX_WR && (XFER_DISABLE_SEL || !XFER_COUNT_NZ)
        && s_q.tx_empty && !wr_en
        |=> s_q.tx_empty
    ) else $error("Transmit-empty cleared while transfers disabled.");

    a_stop_reset: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        $fell(RST) |-> s_q.stop && !TX_START
    ) else $error("Module not stopped after reset.");

    a_stop_gate: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        rd_en && s_q.stop && (rd_ofs != OFS_STOP) |=> HRDATA == '0
    ) else $error("Register read while module stopped.");

    a_tx_end_flag_wr0: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        wr_en && on && (wr_ofs == OFS_STAT) && !HWDATA[ST_TX_END]
        && !etu_done
        |=> !s_q.tx_end
    ) else $error("Transmit-end not cleared by zero write.");

    a_tx_end_flag_xfer: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        on && XFER_TX_WR && !etu_done |=> !s_q.tx_end
    ) else $error("Transmit-end not cleared by controller write.");

    a_tx_end_flag_set: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        etu_done && (s_q.tx_st == SFT_TX_SEND) && s_q.tx_empty
        && !s_q.err_sig
        |=> s_q.tx_end && s_q.irq_stat[IRQ_TX_END]
    ) else $error("Transmit-end not set at end of character.");

    a_tx_end_flag_gap: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        TX_START && !BRG_HALF_TICK |=> !s_q.tx_end [*2]
    ) else $error("Transmit-end set too early after start bit.");

endmodule

// ### bench/sft_peer_model.sv
`timescale 1ns/1ps
module sft_peer_model #(
    parameter int GAP   = 4,
    parameter int TICKS = 30
) (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst,
    // Character from the block.
    input  wire logic       tx_start,
    // Serial events to the block.
    output logic            half_tick,
    output logic            rx_done,
    output logic [7:0]      rx_byte,
    output logic            rx_error,
    output logic            err_signal,
    // Half units seen since the start bit.
    output int              ticks
);
    int phase;

    initial begin
        half_tick = 1'b0;
        ticks = TICKS;
        phase = 0;
        rx_done = 1'b0;
        rx_byte = 8'h00;
        rx_error = 1'b0;
        err_signal = 1'b0;
    end

    // The card's bit clock runs only while a character is on the line.
    // Ticks start after the start pulse so the two never coincide.
    always @(posedge clk) begin
        if (rst || tx_start) begin
            phase <= 0;
            ticks <= rst ? TICKS : 0;
            half_tick <= 1'b0;
        end else if (ticks < TICKS) begin
            phase <= (phase == GAP - 1) ? 0 : phase + 1;
            half_tick <= (phase == GAP - 1);
            ticks <= ticks + ((phase == GAP - 1) ? 1 : 0);
        end else begin
            half_tick <= 1'b0;
        end
    end

    // Kind 0 is a received byte, 1 a receive error, 2 an error signal.
    task automatic pulse(input int kind, input logic [7:0] b);
        @(posedge clk);
        rx_byte <= b;
        rx_done <= (kind == 0);
        rx_error <= (kind == 1);
        err_signal <= (kind == 2);
        @(posedge clk);
        rx_done <= 1'b0;
        rx_error <= 1'b0;
        err_signal <= 1'b0;
        // A released data line must not keep showing the old byte.
        rx_byte <= ~b;
    endtask
endmodule

// ### bench/sft_flag_ctrl_test.sv
`timescale 1ns/1ps
module sft_flag_ctrl_test;
    import sft_pkg::*;
    logic        clk, rst, hsel, hwrite, xwr, xrd, xsrc, xdis, xnz;
    logic        hready, hresp, req_tx, req_rx, irq, tx_start;
    logic        half_tick, rx_done, rx_error, err_sig;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  xdata, rx_data, tx_byte, rx_byte;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          peer_ticks, err_count, total_checks;

    sft_flag_ctrl i_sft_flag_ctrl (
        .SYS_CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
        .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp), .XFER_TX_WR(xwr),
        .XFER_TX_DATA(xdata), .XFER_RX_RD(xrd), .XFER_RX_SRC(xsrc),
        .XFER_DISABLE_SEL(xdis), .XFER_COUNT_NZ(xnz),
        .XFER_RX_DATA(rx_data), .XFER_REQ_TX(req_tx),
        .XFER_REQ_RX(req_rx), .BRG_HALF_TICK(half_tick),
        .RX_DONE(rx_done), .RX_BYTE(rx_byte), .RX_ERROR(rx_error),
        .ERR_SIGNAL(err_sig), .TX_START(tx_start), .TX_BYTE(tx_byte),
        .IRQ(irq));

    sft_peer_model i_sft_peer_model (
        .clk(clk), .rst(rst), .tx_start(tx_start),
        .half_tick(half_tick), .rx_done(rx_done), .rx_byte(rx_byte),
        .rx_error(rx_error), .err_signal(err_sig), .ticks(peer_ticks));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h want %h",
                     $time, what, seen, exp);
        end
    endtask

    // One single word transfer; the bus has no fixed wait count.
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= SIZE_WORD;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input string what);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, exp, what);
        chk(32'(hresp), 32'h0000_0000, "okay");
    endtask

    task automatic ctl(input logic r, input logic dis, input logic nz,
                       input logic src, input logic [7:0] d);
        xdis <= dis;
        xnz <= nz;
        xsrc <= src;
        xdata <= d;
        xwr <= !r;
        xrd <= r;
        @(posedge clk);
        xwr <= 1'b0;
        xrd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic t_stop;
        rd_chk(OFS_STOP, 32'h0000_0001, "stop reset");
        rd_chk(OFS_STAT, 32'h0000_0000, "stat stopped");
        bus(1'b1, OFS_CTRL, 32'h0000_000C);
        @(posedge clk);
        chk(32'(req_tx), 32'h0000_0000, "req stopped");
        bus(1'b1, OFS_STOP, 32'h0000_0000);
        rd_chk(OFS_CTRL, 32'h0000_0000, "ctrl refused");
        rd_chk(OFS_STAT, 32'h0000_0084, "stat reset");
        rd_chk(8'h1C, 32'h0000_0000, "unmapped");
    endtask

    task automatic t_tx_clear;
        bus(1'b1, OFS_CTRL, 32'h0000_0004);
        @(posedge clk);
        chk(32'(req_tx), 32'h0000_0001, "tx request");
        ctl(1'b0, 1'b1, 1'b1, 1'b0, 8'h11);
        rd_chk(OFS_STAT, 32'h0000_0080, "disable set");
        ctl(1'b0, 1'b0, 1'b0, 1'b0, 8'h22);
        rd_chk(OFS_STAT, 32'h0000_0080, "count zero");
        ctl(1'b0, 1'b0, 1'b1, 1'b0, 8'h33);
        rd_chk(OFS_STAT, 32'h0000_0000, "auto clear");
        chk(32'(req_tx), 32'h0000_0000, "tx request off");
    endtask

    task automatic t_tx_end(input logic v, input int half);
        int         n;
        logic [7:0] got;
        n = 0;
        got = 8'h00;
        bus(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
        // Load with transmit off, so no stale byte goes out first.
        bus(1'b1, OFS_CTRL, 32'(v));
        ctl(1'b0, 1'b0, 1'b1, 1'b0, 8'hA5);
        bus(1'b1, OFS_CTRL, 32'h0000_0002 | 32'(v));
        while (irq !== 1'b1 && n < 400) begin
            @(posedge clk);
            if (tx_start === 1'b1) got = tx_byte;
            n++;
        end
        chk(32'(irq), 32'h0000_0001, "end irq");
        chk(32'(got), 32'h0000_00A5, "tx byte");
        chk(32'(peer_ticks), 32'(half), "delay");
        rd_chk(OFS_STAT, 32'h0000_0084, "tx end set");
        bus(1'b1, OFS_STAT, 32'h0000_00FB);
        rd_chk(OFS_STAT, 32'h0000_0080, "tx end clear");
        bus(1'b1, OFS_IRQ_MASK, 32'h0000_0000);
        @(posedge clk);
        chk(32'(irq), 32'h0000_0000, "irq masked");
        bus(1'b1, OFS_IRQ_STAT, 32'h0000_0001);
        bus(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
        @(posedge clk);
        chk(32'(irq), 32'h0000_0000, "irq cleared");
    endtask

    task automatic t_err;
        ctl(1'b0, 1'b0, 1'b1, 1'b0, 8'h5A);
        repeat (20) @(posedge clk);
        i_sft_peer_model.pulse(2, 8'h00);
        repeat (150) @(posedge clk);
        chk(32'(irq), 32'h0000_0000, "no end irq");
        rd_chk(OFS_STAT, 32'h0000_0088, "error stat");
    endtask

    task automatic t_rx;
        bus(1'b1, OFS_CTRL, 32'h0000_0008);
        i_sft_peer_model.pulse(0, 8'h3C);
        @(posedge clk);
        chk(32'(req_rx), 32'h0000_0001, "rx request");
        ctl(1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
        rd_chk(OFS_STAT, 32'h0000_00C8, "wrong source");
        bus(1'b1, OFS_STAT, 32'h0000_00BF);
        rd_chk(OFS_STAT, 32'h0000_0088, "cpu clear");
        i_sft_peer_model.pulse(0, 8'h96);
        ctl(1'b1, 1'b1, 1'b1, 1'b1, 8'h00);
        rd_chk(OFS_STAT, 32'h0000_00C8, "rx disable");
        ctl(1'b1, 1'b0, 1'b1, 1'b1, 8'h00);
        chk(32'(rx_data), 32'h0000_0096, "rx data");
        rd_chk(OFS_STAT, 32'h0000_0088, "rx auto clear");
        i_sft_peer_model.pulse(1, 8'h00);
        @(posedge clk);
        chk(32'({req_tx, req_rx}), 32'h0000_0000, "err request");
        rd_chk(OFS_STAT, 32'h0000_0098, "rx error stat");
    endtask

    initial begin
        rst = 1'b1;
        {hsel, hwrite, xwr, xrd, xsrc, xdis, xnz} = 7'h00;
        htrans = 2'b00;
        hsize = SIZE_WORD;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        xdata = 8'h00;
        err_count = 0;
        total_checks = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_stop;
        t_tx_clear;
        t_tx_end(1'b0, 25);
        t_tx_end(1'b1, 22);
        t_err;
        t_rx;
        complete_run;
    end

    // The whole run needs about five hundred cycles.
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        complete_run;
    end
endmodule
